// ---- hdl/tft_panel_pixel_output.sv ----
// Panel pixel output stage: mode mapping, pin sharing, panel controls, PWM and register slave.
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tft_panel_pixel_output #(
  parameter int PWM_W = 8
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Pixel clocks arriving from the panel clock generator, asynchronous
  input  wire logic        pix_clk0_in,
  input  wire logic        pix_clk1_in,
  // First pixel stream (8:8:8) with its timing
  input  wire logic [23:0] pix_a_rgb,
  input  wire logic        pix_a_hsync,
  input  wire logic        pix_a_vsync,
  input  wire logic        pix_a_de,
  // Second pixel stream (6:6:6) with its timing
  input  wire logic [17:0] pix_b_rgb,
  input  wire logic        pix_b_hsync,
  input  wire logic        pix_b_vsync,
  input  wire logic        pix_b_de,
  // Analog pipe syncs passed through outside dual mode
  input  wire logic        crt_hsync_in,
  input  wire logic        crt_vsync_in,
  // Dedicated panel pins
  output logic [23:0]      panel_data_line,
  output logic             panel_hsync_pin,
  output logic             panel_vsync_pin,
  output logic             panel_pixel_clock_pin,
  output logic             panel_data_enable_pin,
  // Shared general-purpose pins
  output logic [35:24]     panel_data_line_ext,
  output logic [35:24]     panel_data_line_ext_oe,
  output logic             gpio16_out,
  output logic             gpio16_oe,
  output logic             gpio29_out,
  output logic             gpio29_oe,
  // Analog sync pins
  output logic             analog_hsync_pin,
  output logic             analog_vsync_pin,
  // Panel power controls and brightness
  output logic             panel_logic_power_ctrl,
  output logic             panel_enable_ctrl,
  output logic             backlight_ctrl,
  output logic [2:0]       pwm_pin
);

  logic [31:0] ctrl_reg;
  logic [31:0] pwm_cfg_reg [tft_panel_pkg::PWM_CHANNELS];
  logic [1:0]  active_mode_reg;
  logic        hover_reg;
  logic        vover_reg;
  logic [11:0] hcount_reg;
  logic [11:0] vcount_reg;
  logic [11:0] width_reg;
  logic [11:0] height_reg;
  logic [35:0] data_reg;
  logic        ack_reg;
  logic [2:0]  clk0_sync_reg;
  logic [2:0]  clk1_sync_reg;
  logic        vsync_prev_reg;
  logic        de_prev_reg;
  logic        sync1_h_reg;
  logic        sync1_v_reg;
  logic        de1_reg;
  logic        hsync0_reg;
  logic        vsync0_reg;
  logic        de0_reg;
  logic [7:0]  prescale_reg;
  logic        pwm_tick;
  logic        edge0;
  logic        edge1;
  logic        frame_edge;
  logic        line_end;
  logic [1:0]  eff_mode;
  logic        dual;
  logic        wide;
  logic        bus_take;
  logic        wr_take;
  logic [31:0] wmask;

  // Pixel clocks cross in through three flops; the second and third stages feed the edge detect.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clk0_sync_reg <= 3'h0;
      clk1_sync_reg <= 3'h0;
    end else begin
      clk0_sync_reg <= {clk0_sync_reg[1:0], pix_clk0_in};
      clk1_sync_reg <= {clk1_sync_reg[1:0], pix_clk1_in};
    end
  end

  assign edge0      = clk0_sync_reg[1] && !clk0_sync_reg[2];
  assign edge1      = clk1_sync_reg[1] && !clk1_sync_reg[2];
  assign frame_edge = edge0 && pix_a_vsync && !vsync_prev_reg;
  assign line_end   = edge0 && de_prev_reg && !pix_a_de;
  assign eff_mode   = frame_edge ? ctrl_reg[1:0] : active_mode_reg;
  assign dual       = (active_mode_reg == tft_panel_pkg::MODE_DUAL);
  assign wide       = dual || (active_mode_reg == tft_panel_pkg::MODE_36);

  // Avalon slave: every access waits exactly one cycle.
  assign waitrequest = (read || write) && !ack_reg;
  assign bus_take    = (read || write) && ack_reg;
  assign wr_take     = write && ack_reg;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = byteenable[i] ? 8'hFF : 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read || write) && !ack_reg;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= tft_panel_pkg::CTRL_RESET;
    end else if (wr_take && address == tft_panel_pkg::CTRL_OFS) begin
      ctrl_reg <= (ctrl_reg & ~wmask) | (writedata & wmask);
    end
  end

  // The control pins are plain register bits: nothing in hardware sequences them.
  assign panel_logic_power_ctrl = ctrl_reg[tft_panel_pkg::CTRL_POWER_BIT];
  assign panel_enable_ctrl      = ctrl_reg[tft_panel_pkg::CTRL_ENABLE_BIT];
  assign backlight_ctrl         = ctrl_reg[tft_panel_pkg::CTRL_LIGHT_BIT];

  // Committing only at the leading vsync edge avoids a frame split between two pin maps.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      active_mode_reg <= tft_panel_pkg::MODE_18;
    end else if (frame_edge) begin
      active_mode_reg <= ctrl_reg[1:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      vsync_prev_reg <= 1'b0;
      de_prev_reg    <= 1'b0;
    end else if (edge0) begin
      vsync_prev_reg <= pix_a_vsync;
      de_prev_reg    <= pix_a_de;
    end
  end

  // Size measurement saturates at the counter width; anything beyond the limit is flagged.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hcount_reg <= 12'h000;
      vcount_reg <= 12'h000;
      width_reg  <= 12'h000;
      height_reg <= 12'h000;
    end else begin
      if (edge0 && pix_a_de && hcount_reg != 12'hFFF) begin
        hcount_reg <= hcount_reg + 12'h001;
      end else if (line_end) begin
        hcount_reg <= 12'h000;
      end
      if (line_end) begin
        width_reg <= hcount_reg;
      end
      if (frame_edge) begin
        height_reg <= vcount_reg;
        vcount_reg <= 12'h000;
      end else if (line_end && vcount_reg != 12'hFFF) begin
        vcount_reg <= vcount_reg + 12'h001;
      end
    end
  end

  // Oversize flags are sticky and cleared by writing one; a new event wins over the clear.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hover_reg <= 1'b0;
      vover_reg <= 1'b0;
    end else begin
      if (line_end && hcount_reg > 12'(tft_panel_pkg::MAX_WIDTH)) begin
        hover_reg <= 1'b1;
      end else if (wr_take && address == tft_panel_pkg::STATUS_OFS && byteenable[0]
                   && writedata[tft_panel_pkg::STAT_HOVER_BIT]) begin
        hover_reg <= 1'b0;
      end
      if (frame_edge && vcount_reg > 12'(tft_panel_pkg::MAX_HEIGHT)) begin
        vover_reg <= 1'b1;
      end else if (wr_take && address == tft_panel_pkg::STATUS_OFS && byteenable[0]
                   && writedata[tft_panel_pkg::STAT_VOVER_BIT]) begin
        vover_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < tft_panel_pkg::PWM_CHANNELS; i++) begin
        pwm_cfg_reg[i] <= tft_panel_pkg::PWM_RESET;
      end
    end else if (wr_take) begin
      for (int i = 0; i < tft_panel_pkg::PWM_CHANNELS; i++) begin
        if (address == tft_panel_pkg::PWM0_OFS + 5'(4 * i)) begin
          pwm_cfg_reg[i] <= (pwm_cfg_reg[i] & ~wmask) | (writedata & wmask);
        end
      end
    end
  end

  // Unmapped addresses read as zero and ignore writes.
  // Loaded in the wait cycle so the word already stands when the master sees waitrequest low.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_reg) begin
      readdata <= 32'h0000_0000;
      case (address)
        tft_panel_pkg::CTRL_OFS:   readdata <= ctrl_reg;
        tft_panel_pkg::STATUS_OFS: readdata <= {27'h0, ctrl_reg[1:0] != active_mode_reg,
                                               vover_reg, hover_reg, active_mode_reg};
        tft_panel_pkg::SIZE_OFS:   readdata <= {4'h0, height_reg, 4'h0, width_reg};
        default: begin
          for (int i = 0; i < tft_panel_pkg::PWM_CHANNELS; i++) begin
            if (address == tft_panel_pkg::PWM0_OFS + 5'(4 * i)) begin
              readdata <= pwm_cfg_reg[i];
            end
          end
        end
      endcase
    end
  end

  // Pixel data register. Unused lines are forced low by every mode change and every pixel.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      data_reg <= 36'h0_0000_0000;
    end else if (edge0) begin
      case (eff_mode)
        tft_panel_pkg::MODE_24: begin
          data_reg <= {12'h000, pix_a_rgb};
        end
        tft_panel_pkg::MODE_36: begin
          data_reg <= {pix_b_rgb[17:14], pix_b_rgb[11:8], pix_b_rgb[5:2],
                       pix_a_rgb[23:18], pix_b_rgb[13:12],
                       pix_a_rgb[15:10], pix_b_rgb[7:6],
                       pix_a_rgb[7:2], pix_b_rgb[1:0]};
        end
        tft_panel_pkg::MODE_DUAL: begin
          data_reg[23:18] <= pix_a_rgb[23:18];
          data_reg[15:10] <= pix_a_rgb[15:10];
          data_reg[7:2]   <= pix_a_rgb[7:2];
          if (!dual) begin
            data_reg[35:24] <= 12'h000;
            data_reg[17:16] <= 2'h0;
            data_reg[9:8]   <= 2'h0;
            data_reg[1:0]   <= 2'h0;
          end
        end
        default: begin
          data_reg <= {12'h000, pix_a_rgb[23:18], 2'h0, pix_a_rgb[15:10], 2'h0,
                       pix_a_rgb[7:2], 2'h0};
        end
      endcase
    end else if (edge1 && dual) begin
      data_reg[35:24] <= {pix_b_rgb[17:14], pix_b_rgb[11:8], pix_b_rgb[5:2]};
      data_reg[17:16] <= pix_b_rgb[13:12];
      data_reg[9:8]   <= pix_b_rgb[7:6];
      data_reg[1:0]   <= pix_b_rgb[1:0];
    end
  end

  assign panel_data_line     = data_reg[23:0];
  assign panel_data_line_ext = data_reg[35:24];

  // Shared pins are released to their other functions unless a wide mode holds them.
  assign panel_data_line_ext_oe = wide ? 12'hFFF : 12'h000;

  // First panel timing on the dedicated pins in every mode.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hsync0_reg <= 1'b0;
      vsync0_reg <= 1'b0;
      de0_reg    <= 1'b0;
    end else if (edge0) begin
      hsync0_reg <= pix_a_hsync;
      vsync0_reg <= pix_a_vsync;
      de0_reg    <= pix_a_de;
    end
  end

  assign panel_hsync_pin       = hsync0_reg;
  assign panel_vsync_pin       = vsync0_reg;
  assign panel_data_enable_pin = de0_reg;
  assign panel_pixel_clock_pin = clk0_sync_reg[2];

  // Second panel timing, captured on its own pixel clock.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_h_reg <= 1'b0;
      sync1_v_reg <= 1'b0;
      de1_reg     <= 1'b0;
    end else if (edge1) begin
      sync1_h_reg <= pix_b_hsync;
      sync1_v_reg <= pix_b_vsync;
      de1_reg     <= pix_b_de;
    end
  end

  assign analog_hsync_pin = dual ? sync1_h_reg : crt_hsync_in;
  assign analog_vsync_pin = dual ? sync1_v_reg : crt_vsync_in;
  assign gpio16_out       = clk1_sync_reg[2];
  assign gpio16_oe        = dual;
  assign gpio29_out       = de1_reg;
  assign gpio29_oe        = dual;

  // Shared PWM tick from a divider keeps the design on one clock.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prescale_reg <= 8'h00;
    end else if (pwm_tick) begin
      prescale_reg <= 8'h00;
    end else begin
      prescale_reg <= prescale_reg + 8'h01;
    end
  end

  assign pwm_tick = (prescale_reg == 8'(tft_panel_pkg::PWM_PRESCALE - 1));

  generate
    for (genvar g = 0; g < tft_panel_pkg::PWM_CHANNELS; g++) begin : g_pwm
      pwm_channel #(
        .CNT_W (PWM_W)
      ) u_pwm (
        .core_clk (core_clk),
        .nrst     (nrst),
        .tick     (pwm_tick),
        .enable   (pwm_cfg_reg[g][tft_panel_pkg::PWM_EN_BIT]),
        .duty     (pwm_cfg_reg[g][PWM_W-1:0]),
        .pwm_out  (pwm_pin[g])
      );
    end
  endgenerate

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  mode_commit_a: assert property ($changed(active_mode_reg) |-> $past(frame_edge))
    else $error("mode changed outside a frame boundary");
  unused_low_a: assert property (active_mode_reg == tft_panel_pkg::MODE_18 && $past(edge0)
    |-> data_reg[17:16] == 2'h0 && data_reg[9:8] == 2'h0 && data_reg[1:0] == 2'h0 && data_reg[35:24] == 12'h000)
    else $error("unused data lines not low in 18-bit mode");
  shared_pins_a: assert property ($rose(panel_data_line_ext_oe[24]) |-> $past(frame_edge))
    else $error("shared pins taken outside a frame boundary");
  control_pins_a: assert property ($changed(backlight_ctrl) || $changed(panel_enable_ctrl)
    |-> $past(wr_take && address == tft_panel_pkg::CTRL_OFS))
    else $error("panel control moved without a write");
  map_18_a: assert property (edge0 && eff_mode == tft_panel_pkg::MODE_18
    |=> panel_data_line[23:18] == $past(pix_a_rgb[23:18]) && panel_data_line[7:2] == $past(pix_a_rgb[7:2]))
    else $error("18-bit mapping wrong");
  map_36_a: assert property (edge0 && eff_mode == tft_panel_pkg::MODE_36
    |=> panel_data_line_ext[35:32] == $past(pix_b_rgb[17:14]) && panel_data_line[1:0] == $past(pix_b_rgb[1:0]))
    else $error("second pixel mapping wrong");
  dual_second_a: assert property (edge1 && !edge0 && dual
    |=> panel_data_line_ext[27:24] == $past(pix_b_rgb[5:2]) && panel_data_line[9:8] == $past(pix_b_rgb[7:6]))
    else $error("second panel mapping wrong");
  dual_sync_a: assert property (edge1 && dual ##1 dual |-> analog_hsync_pin == $past(pix_b_hsync))
    else $error("second panel sync not on analog pin");
  oversize_a: assert property (line_end && hcount_reg > 12'(tft_panel_pkg::MAX_WIDTH) |=> hover_reg)
    else $error("oversize line not flagged");
  bus_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer later than one wait cycle");

  mode_24_c: cover property (active_mode_reg == tft_panel_pkg::MODE_24);
  mode_36_c: cover property (active_mode_reg == tft_panel_pkg::MODE_36);
  mode_dual_c: cover property (dual && edge1);
  mode_swap_c: cover property (frame_edge && ctrl_reg[1:0] != active_mode_reg);

endmodule : tft_panel_pixel_output

// ---- hdl/tft_panel_pkg.sv ----
// Constants, register map and mode codes for the TFT panel pixel output stage.
//
// Operation
// - The stage drives one 18-bit, one 24-bit, one 36-bit two-pixel or two independent 18-bit panels.
// - Timing logic handles active sizes up to 1920 by 1440 and only flags anything larger.
// - Logic power, panel enable and backlight outputs move only on a software register write.
// - The backlight output switches the backlight; software raises it after the inverter supply is up.
// - Three PWM outputs are provided for board brightness control.
// - In dual mode the second panel takes its syncs on the analog sync pins, clock on GPIO 16, enable on GPIO 29.
// - Single 18-bit mode puts red, green, blue 5..0 on lines 23..18, 15..10, 7..2, other lines unused.
// - In 36-bit mode the first pixel's components sit on lines 23..18, 15..10 and 7..2.
// - In 36-bit mode the second pixel's bits 5..2 use lines 35..24 and its bits 1..0 lines 17..16, 9..8, 1..0.
// - In dual mode the first panel is mapped exactly as in single 18-bit mode.
// - In dual mode the second panel uses lines 35..24 for bits 5..2 and 17..16, 9..8, 1..0 for bits 1..0.
// - Lines 35..32 and 31..24 are shared general-purpose pins and are driven only when the mode selects them.
package tft_panel_pkg;

  localparam logic [1:0] MODE_18   = 2'h0;
  localparam logic [1:0] MODE_24   = 2'h1;
  localparam logic [1:0] MODE_36   = 2'h2;
  localparam logic [1:0] MODE_DUAL = 2'h3;

  localparam logic [4:0] CTRL_OFS   = 5'h00;
  localparam logic [4:0] STATUS_OFS = 5'h04;
  localparam logic [4:0] SIZE_OFS   = 5'h08;
  localparam logic [4:0] PWM0_OFS   = 5'h0C;

  localparam int CTRL_POWER_BIT  = 2;
  localparam int CTRL_ENABLE_BIT = 3;
  localparam int CTRL_LIGHT_BIT  = 4;
  localparam int STAT_HOVER_BIT  = 2;
  localparam int STAT_VOVER_BIT  = 3;
  localparam int STAT_PEND_BIT   = 4;
  localparam int SIZE_V_LSB      = 16;
  localparam int PWM_EN_BIT      = 8;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PWM_RESET  = 32'h0000_0000;

  localparam int MAX_WIDTH    = 1920;
  localparam int MAX_HEIGHT   = 1440;
  localparam int PWM_CHANNELS = 3;
  localparam int PWM_PRESCALE = 16;

endpackage : tft_panel_pkg

// ---- hdl/pwm_channel.sv ----
// One brightness PWM channel advanced by a shared tick enable.
`timescale 1ns/1ps
module pwm_channel #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Control
  input  wire logic             tick,
  input  wire logic             enable,
  input  wire logic [CNT_W-1:0] duty,
  // Output
  output logic                  pwm_out
);

  logic [CNT_W-1:0] count_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
    end else if (tick) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // Duty zero keeps the output low for the whole period.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= enable && (count_reg < duty);
    end
  end

endmodule : pwm_channel

// ---- testbench/tft_panel_model.sv ----
// Listening model of the panels: latches all data lines and enable on the first panel clock's falling edge, the second panel's enable on its own.
`timescale 1ns/1ps
module tft_panel_model (
  // Panel pins
  input  wire logic [23:0]  panel_data_line,
  input  wire logic [35:24] panel_data_line_ext,
  input  wire logic [35:24] panel_data_line_ext_oe,
  input  wire logic         panel_pixel_clock_pin,
  input  wire logic         panel_data_enable_pin,
  input  wire logic         gpio16_out,
  input  wire logic         gpio29_out,
  // Captured view
  output logic [35:0]       cap_pixel,
  output logic              cap_de,
  output logic              cap2_de
);
  // Released extension lines read as low, so a stale level cannot pass for pixel data.
  always @(negedge panel_pixel_clock_pin) begin
    cap_pixel <= {panel_data_line_ext & panel_data_line_ext_oe, panel_data_line};
    cap_de    <= panel_data_enable_pin;
  end
  always @(negedge gpio16_out) begin
    cap2_de <= gpio29_out;
  end
endmodule : tft_panel_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the panel pixel output stage.
`timescale 1ns/1ps
module testbench;
  localparam logic [23:0] A_PIX = 24'hABCDEF;
  localparam logic [17:0] B_PIX = 18'h35A96;
  logic         core_clk, nrst, read, write, waitrequest, pix_clk0_in, pix_clk1_in;
  logic [4:0]   address;
  logic [3:0]   byteenable;
  logic [31:0]  writedata, readdata, rd;
  logic [23:0]  pix_a_rgb, panel_data_line;
  logic [17:0]  pix_b_rgb;
  logic         pix_a_hsync, pix_a_vsync, pix_a_de, pix_b_hsync, pix_b_vsync, pix_b_de, crt_hsync_in, crt_vsync_in;
  logic         panel_hsync_pin, panel_vsync_pin, panel_pixel_clock_pin, panel_data_enable_pin;
  logic [35:24] panel_data_line_ext, panel_data_line_ext_oe;
  logic         gpio16_out, gpio16_oe, gpio29_out, gpio29_oe, analog_hsync_pin, analog_vsync_pin;
  logic         panel_logic_power_ctrl, panel_enable_ctrl, backlight_ctrl;
  logic [2:0]   pwm_pin;
  logic [35:0]  cap_pixel;
  logic         cap_de, cap2_de;
  int           num_errors, samples_checked, cycles;

  tft_panel_pixel_output tft_panel_pixel_output_i (
    .core_clk, .nrst, .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest,
    .pix_clk0_in, .pix_clk1_in, .pix_a_rgb, .pix_a_hsync, .pix_a_vsync, .pix_a_de,
    .pix_b_rgb, .pix_b_hsync, .pix_b_vsync, .pix_b_de, .crt_hsync_in, .crt_vsync_in,
    .panel_data_line, .panel_hsync_pin, .panel_vsync_pin, .panel_pixel_clock_pin, .panel_data_enable_pin,
    .panel_data_line_ext, .panel_data_line_ext_oe, .gpio16_out, .gpio16_oe, .gpio29_out, .gpio29_oe,
    .analog_hsync_pin, .analog_vsync_pin, .panel_logic_power_ctrl, .panel_enable_ctrl, .backlight_ctrl,
    .pwm_pin
  );

  tft_panel_model tft_panel_model_i (
    .panel_data_line, .panel_data_line_ext, .panel_data_line_ext_oe, .panel_pixel_clock_pin,
    .panel_data_enable_pin, .gpio16_out, .gpio29_out, .cap_pixel, .cap_de, .cap2_de
  );

  always #4 core_clk = ~core_clk;
  always #62.5 pix_clk0_in = ~pix_clk0_in;
  // The second pixel clock starts 21 ns late, so its edges keep a fixed offset from the first.
  initial begin
    #21;
    forever #62.5 pix_clk1_in = ~pix_clk1_in;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      num_errors++;
      results();
    end
  end

  task automatic results;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t register got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t pins got %h expected %h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    address    <= a;
    writedata  <= wd;
    byteenable <= be;
    write      <= wr;
    read       <= ~wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    // Let the completing edge settle before any caller looks at the outputs.
    @(negedge core_clk);
    if (n >= 50) begin
      num_errors++;
      $display("[FAIL] t=%0t bus answer missing", $time);
    end
  endtask : bus

  // One pixel period: inputs change just after the pixel clock falls, far from its sampling rise.
  task automatic pix(input logic hs, input logic vs, input logic de);
    @(negedge pix_clk0_in);
    @(posedge core_clk);
    pix_a_hsync <= hs;
    pix_a_vsync <= vs;
    pix_a_de    <= de;
  endtask : pix

  function automatic logic [35:0] ctl();
    return {33'h0, panel_logic_power_ctrl, panel_enable_ctrl, backlight_ctrl};
  endfunction : ctl

  function automatic logic [35:0] exp_map(input logic [1:0] m);
    case (m)
      tft_panel_pkg::MODE_18: return {12'h0, A_PIX[23:18], 2'h0, A_PIX[15:10], 2'h0, A_PIX[7:2], 2'h0};
      tft_panel_pkg::MODE_24: return {12'h0, A_PIX};
      default: return {B_PIX[17:14], B_PIX[11:8], B_PIX[5:2], A_PIX[23:18], B_PIX[13:12],
                       A_PIX[15:10], B_PIX[7:6], A_PIX[7:2], B_PIX[1:0]};
    endcase
  endfunction : exp_map

  task automatic t_reset;
    bus(1'b0, tft_panel_pkg::CTRL_OFS, 32'h0, 4'hF);
    chk_reg(rd, tft_panel_pkg::CTRL_RESET);
    bus(1'b0, tft_panel_pkg::PWM0_OFS, 32'h0, 4'hF);
    chk_reg(rd, tft_panel_pkg::PWM_RESET);
    bus(1'b1, 5'h1C, 32'h1F, 4'hF);
    bus(1'b0, 5'h1C, 32'h0, 4'hF);
    chk_reg(rd, 32'h0);
    bus(1'b0, tft_panel_pkg::CTRL_OFS, 32'h0, 4'hF);
    chk_reg(rd, tft_panel_pkg::CTRL_RESET);
    chk_pin(ctl(), 36'h0);
  endtask : t_reset

  task automatic t_ctrl;
    bus(1'b1, tft_panel_pkg::CTRL_OFS, 32'h14, 4'hF);
    chk_pin(ctl(), 36'h5);
    bus(1'b1, tft_panel_pkg::CTRL_OFS, 32'h0, 4'hE);
    chk_pin(ctl(), 36'h5);
    repeat (4) pix(1'b0, 1'b1, 1'b0);
    chk_pin(ctl(), 36'h5);
    bus(1'b1, tft_panel_pkg::CTRL_OFS, 32'h08, 4'hF);
    chk_pin(ctl(), 36'h2);
  endtask : t_ctrl

  task automatic t_size;
    for (int w = 1920; w <= 1921; w++) begin
      repeat (w) pix(1'b0, 1'b0, 1'b1);
      pix(1'b1, 1'b0, 1'b0);
      pix(1'b0, 1'b0, 1'b0);
      if (w == 1920) begin
        bus(1'b0, tft_panel_pkg::SIZE_OFS, 32'h0, 4'hF);
        chk_reg(rd & 32'hFFF, 32'h780);
      end
      bus(1'b0, tft_panel_pkg::STATUS_OFS, 32'h0, 4'hF);
      chk_reg(rd & 32'h4, (w > 1920) ? 32'h4 : 32'h0);
    end
    bus(1'b1, tft_panel_pkg::STATUS_OFS, 32'h4, 4'h1);
    bus(1'b0, tft_panel_pkg::STATUS_OFS, 32'h0, 4'hF);
    chk_reg(rd & 32'h4, 32'h0);
  endtask : t_size

  task automatic t_modes;
    logic [1:0] m;
    logic [1:0] prev;
    prev = tft_panel_pkg::MODE_18;
    for (int i = 1; i <= 4; i++) begin
      m = 2'(i);
      bus(1'b1, tft_panel_pkg::CTRL_OFS, {27'h0, 3'b101, m}, 4'hF);
      bus(1'b0, tft_panel_pkg::STATUS_OFS, 32'h0, 4'hF);
      chk_reg(rd & 32'h13, {27'h0, 1'b1, 2'h0, prev});
      pix(1'b0, 1'b0, 1'b1);
      pix(1'b0, 1'b1, 1'b1);
      repeat (3) pix(1'b0, 1'b0, 1'b1);
      bus(1'b0, tft_panel_pkg::STATUS_OFS, 32'h0, 4'hF);
      chk_reg(rd & 32'h13, {30'h0, m});
      chk_pin(cap_pixel, exp_map(m));
      chk_pin({24'h0, panel_data_line_ext_oe}, {24'h0, {12{m[1]}}});
      chk_pin({32'h0, gpio16_oe, gpio29_oe, analog_hsync_pin, analog_vsync_pin}, (m == 2'h3) ? 36'hE : 36'h1);
      chk_pin({35'h0, cap_de}, 36'h1);
      if (m == tft_panel_pkg::MODE_DUAL) chk_pin({35'h0, cap2_de}, 36'h1);
      chk_pin(ctl(), 36'h5);
      prev = m;
    end
  endtask : t_modes

  task automatic t_pwm;
    int cnt [3] = '{0, 0, 0};
    chk_pin({33'h0, pwm_pin}, 36'h0);
    for (int j = 0; j < 3; j++) bus(1'b1, 5'(tft_panel_pkg::PWM0_OFS + 4 * j), {23'h0, 1'b1, 8'(64 * (j + 1))}, 4'hF);
    repeat (512) @(posedge core_clk);
    repeat (8192) begin
      @(posedge core_clk);
      #1;
      for (int j = 0; j < 3; j++) cnt[j] += int'(pwm_pin[j]);
    end
    for (int j = 0; j < 3; j++) chk_pin({35'h0, cnt[j] > 2048 * (j + 1) - 48 && cnt[j] < 2048 * (j + 1) + 48}, 36'h1);
  endtask : t_pwm

  initial begin
    {core_clk, pix_clk0_in, pix_clk1_in, nrst, read, write, pix_a_hsync, pix_a_vsync, pix_a_de} = '0;
    {pix_b_vsync, crt_hsync_in, address, byteenable, writedata} = '0;
    {pix_b_hsync, pix_b_de, crt_vsync_in} = 3'h7;
    pix_a_rgb = A_PIX;
    pix_b_rgb = B_PIX;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_ctrl();
    t_size();
    t_modes();
    t_pwm();
    results();
  end
endmodule : testbench
